// [bench/vacuum_condition_monitor_bench.sv]
// Purpose: self-checking bench of the vacuum condition monitor
// Assumes: ms tick shortened to 4 clocks, plant drives the vacuum
// Notes:   waits are bounded, checks go through chk
`timescale 1ns/1ps
module vacuum_condition_monitor_bench
	import vcm_pkg::*;
;
	localparam int MSC = 4;
	logic SYS_CLK_I, RST_N_I, SUCTION_I, BLOW_I, CONTROL_WITH_SHUTOFF_I, rj;
	logic CONTINUOUS_SUCTION_INHIBIT_I, EVAC_LIMIT_WR_I, AUTOSET_I, EXT_PRESSURE_VALID_I;
	logic CLEAR_DIAG_I, FACTORY_RESET_I, ERR_EVENT_I;
	logic [VAC_W-1:0] VACUUM_I, UPPER_SWITCH_POINT_I, UPPER_POINT_HYSTERESIS_I;
	logic [VAC_W-1:0] PART_PRESENT_POINT_I, PART_PRESENT_HYSTERESIS_I, ceil_v, leak_v;
	logic [13:0] EVAC_LIMIT_I, EVAC_LIMIT_O;
	logic [7:0] EXT_PRESSURE_I;
	logic [CODE_W-1:0] ERR_CODE_I;
	logic [5:0] DIAG_IDX_I, DIAG_COUNT_O;
	logic [3:0] TREND_IDX_I, TREND_COUNT_O;
	logic SUCTION_VALVE_O, CONT_SUCTION_O, UPPER_WARN_O, EVAC_WARN_O, LEAK_WARN_O;
	logic DYN_WARN_O, STATUS_YELLOW_O, EVAC_REJECT_O;
	logic [MS_W-1:0] FIRST_EVACUATION_INTERVAL_O, SECOND_EVACUATION_INTERVAL_O;
	logic [MS_W-1:0] LEAK_RATE_O, LEAK_LIMIT_O;
	logic [VAC_W-1:0] DYN_PRESSURE_O;
	logic [6:0] PERF_O, AIR_PCT_O;
	logic [31:0] AIR_ABS_O;
	logic [CNT_W-1:0] SUCTION_CYCLE_COUNTER_O;
	logic [DIAG_W-1:0] DIAG_ENTRY_O;
	logic [TREND_W-1:0] TREND_RECORD_O;
	int errors = 0;
	int cmp_count = 0;
	vcm_monitor #(.TICK_CYCLES_P(MSC)) dut (.*);
	vcm_plant #(.MS_CLK(MSC)) plant (.clk_i(SYS_CLK_I), .valve_i(SUCTION_VALVE_O),
		.ceil_i(ceil_v), .leak_i(leak_v), .vac_o(VACUUM_I));
	initial
	begin
		SYS_CLK_I = 1'b0;
		forever #2 SYS_CLK_I = ~SYS_CLK_I;
	end
	task automatic report_and_stop();
		$display("errors %0d comparisons %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			errors++;
			$display("unexpected %s expected %0h seen %0h", nm, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge SYS_CLK_I);
		#1;
	endtask
	function automatic logic cond(input int k);
		case (k)
			0: return VACUUM_I == 10'h000;
			1: return UPPER_WARN_O === 1'b1;
			2: return EVAC_WARN_O === 1'b1;
			3: return CONT_SUCTION_O === 1'b1;
			4: return LEAK_WARN_O === 1'b1;
			default: return VACUUM_I >= ceil_v;
		endcase
	endfunction
	task automatic wait_on(input int k, input int lim);
		int n;
		n = 0;
		while (!cond(k) && n < lim)
		begin
			tick(1);
			n++;
		end
		if (n >= lim)
		begin
			errors++;
			$display("unexpected timeout in wait %0d", k);
			report_and_stop();
		end
	endtask
	task automatic wr_limit(input logic [13:0] v, input logic r);
		EVAC_LIMIT_I <= v;
		EVAC_LIMIT_WR_I <= 1'b1;
		tick(1);
		EVAC_LIMIT_WR_I <= 1'b0;
		rj = EVAC_REJECT_O;
		tick(1);
		rj = rj | EVAC_REJECT_O;
		chk("evac_reject", {31'h0, r}, {31'h0, rj});
	endtask
	task automatic pulse_autoset();
		AUTOSET_I <= 1'b1;
		tick(1);
		AUTOSET_I <= 1'b0;
		tick(3);
	endtask
	// ************************************************
	// scenarios
	// ************************************************
	initial
	begin
		{RST_N_I, SUCTION_I, BLOW_I, CONTROL_WITH_SHUTOFF_I, EVAC_LIMIT_WR_I} = '0;
		{CONTINUOUS_SUCTION_INHIBIT_I, AUTOSET_I, EXT_PRESSURE_VALID_I, CLEAR_DIAG_I} = '0;
		{FACTORY_RESET_I, ERR_EVENT_I, EVAC_LIMIT_I, EXT_PRESSURE_I, ERR_CODE_I} = '0;
		{DIAG_IDX_I, TREND_IDX_I} = '0;
		UPPER_SWITCH_POINT_I = 10'h258;
		UPPER_POINT_HYSTERESIS_I = 10'h0C8;
		PART_PRESENT_POINT_I = 10'h12C;
		PART_PRESENT_HYSTERESIS_I = 10'h014;
		ceil_v = 10'h190;
		leak_v = 10'h001;
		tick(20);
		RST_N_I <= 1'b1;
		tick(1);
		chk("leak_limit", 32'h64, LEAK_LIMIT_O);
		wr_limit(14'h2EE0, 1'b1);
		chk("evac_limit", 32'h0, EVAC_LIMIT_O);
		wr_limit(14'h2706, 1'b0);
		chk("evac_limit", 32'h2706, EVAC_LIMIT_O);
		wr_limit(14'h2707, 1'b1);
		wr_limit(14'h0001, 1'b0);
		SUCTION_I <= 1'b1;
		tick(DYN_TIME_MS * MSC + 40);
		chk("dyn_pressure", 32'h190, DYN_PRESSURE_O);
		chk("dyn_warn", 32'h1, DYN_WARN_O);
		chk("perf", 32'h0, PERF_O);
		chk("upper_warn", 32'h0, UPPER_WARN_O);
		chk("t0_ms", 32'h1, (FIRST_EVACUATION_INTERVAL_O - 16'h0049) <= 16'h0004);
		SUCTION_I <= 1'b0;
		wait_on(1, 20);
		chk("yellow", 32'h1, STATUS_YELLOW_O);
		chk("cycles", 32'h1, SUCTION_CYCLE_COUNTER_O);
		BLOW_I <= 1'b1;
		tick(400);
		BLOW_I <= 1'b0;
		wait_on(0, 4000);
		ceil_v <= 10'h3E8;
		SUCTION_I <= 1'b1;
		tick(3);
		chk("upper_warn", 32'h0, UPPER_WARN_O);
		chk("air_abs", 32'h0, AIR_ABS_O);
		chk("air_pct", 32'h1, (AIR_PCT_O - 7'h4B) <= 7'h06);
		wait_on(2, 1000);
		wait_on(5, 2000);
		tick(DYN_TIME_MS * MSC);
		SUCTION_I <= 1'b0;
		tick(3);
		chk("upper_warn", 32'h0, UPPER_WARN_O);
		chk("t1_ms", 32'h1, (SECOND_EVACUATION_INTERVAL_O - 16'h0049) <= 16'h0004);
		chk("dyn_pressure", 32'h0, DYN_PRESSURE_O);
		chk("dyn_warn", 32'h0, DYN_WARN_O);
		chk("perf", 32'h0, PERF_O);
		pulse_autoset();
		chk("leak_limit", 32'hA, LEAK_LIMIT_O);
		chk("evac_limit", 32'h1, (EVAC_LIMIT_O - 14'h007B) <= 14'h0004);
		chk("trend_count", 32'h1, TREND_COUNT_O);
		chk("trend_cycles", 32'h2, TREND_RECORD_O[31:0]);
		wait_on(0, 6000);
		wr_limit(14'h0000, 1'b0);
		EXT_PRESSURE_VALID_I <= 1'b1;
		EXT_PRESSURE_I <= 8'h06;
		CONTROL_WITH_SHUTOFF_I <= 1'b1;
		SUCTION_I <= 1'b1;
		tick(3);
		chk("air_abs", 32'h1, AIR_ABS_O != 32'h0);
		wait_on(4, 2000);
		tick(2);
		chk("valve", 32'h1, SUCTION_VALVE_O);
		chk("leak_rate", 32'h1, (LEAK_RATE_O - 16'h03CA) <= 16'h0028);
		chk("evac_warn", 32'h0, EVAC_WARN_O);
		wait_on(3, 4000);
		SUCTION_I <= 1'b0;
		tick(2);
		wait_on(0, 6000);
		CONTINUOUS_SUCTION_INHIBIT_I <= 1'b1;
		SUCTION_I <= 1'b1;
		tick(3);
		wait_on(4, 2000);
		tick(5 * LEAK_WIN_MS * MSC);
		chk("cont", 32'h0, CONT_SUCTION_O);
		SUCTION_I <= 1'b0;
		tick(3);
		ERR_CODE_I <= 4'h9;
		ERR_EVENT_I <= 1'b1;
		tick(1);
		ERR_EVENT_I <= 1'b0;
		tick(3);
		chk("diag_entry", 32'h1, DIAG_ENTRY_O === {4'h9, 32'h4});
		chk("diag_count", 32'h1, DIAG_COUNT_O > 6'h01);
		CLEAR_DIAG_I <= 1'b1;
		tick(1);
		CLEAR_DIAG_I <= 1'b0;
		tick(2);
		chk("diag_count", 32'h0, DIAG_COUNT_O);
		ERR_EVENT_I <= 1'b1;
		FACTORY_RESET_I <= 1'b1;
		tick(1);
		{ERR_EVENT_I, FACTORY_RESET_I} <= 2'h0;
		tick(2);
		chk("diag_count", 32'h1, DIAG_COUNT_O);
		chk("leak_limit", 32'h64, LEAK_LIMIT_O);
		chk("evac_limit", 32'h0, EVAC_LIMIT_O);
		report_and_stop();
	end
endmodule

// [bench/vcm_plant.sv]
// Purpose: vacuum plant behind the suction valve
// Assumes: one ms is MS_CLK clocks
// Notes:   rises one mbar a clock with valve on, leaks per ms with it off
`timescale 1ns/1ps
module vcm_plant
	import vcm_pkg::*;
#(
	parameter int MS_CLK = 4
)
(
	input  wire logic             clk_i,
	input  wire logic             valve_i,
	input  wire logic [VAC_W-1:0] ceil_i,
	input  wire logic [VAC_W-1:0] leak_i,
	output logic      [VAC_W-1:0] vac_o
);
	int ms_cnt = 0;
	initial vac_o = '0;
	always @(posedge clk_i)
	begin
		ms_cnt <= (ms_cnt + 1) % MS_CLK;
		if (valve_i && vac_o < ceil_i)
			vac_o <= vac_o + 10'h001;
		else if (!valve_i && ms_cnt == 0)
			vac_o <= (vac_o > leak_i) ? vac_o - leak_i : 10'h000;
	end
endmodule

// [verilog/vcm_monitor.sv]
// Purpose: condition monitoring and trend recording of a vacuum ejector
// Assumes: inputs synchronous to SYS_CLK_I, vacuum in mbar, pulses one cycle
// Notes:   buffers are flip-flops; retention across power loss is up to the
//          storage behind them, RST_N_I clears them like a factory erase
`timescale 1ns/1ps
module vcm_monitor
	import vcm_pkg::*;
#(
	parameter int                TICK_CYCLES_P = TICK_CYCLES,
	parameter logic [MS_W-1:0]   LEAK_TOL      = 16'h000A,
	parameter logic [MS_W-1:0]   EVAC_TOL      = 16'h0032,
	parameter logic [7:0]        NOZZLE_K      = 8'h04
)
(
	input  wire logic                   SYS_CLK_I,
	input  wire logic                   RST_N_I,
	input  wire logic [VAC_W-1:0]       VACUUM_I,
	input  wire logic                   SUCTION_I,
	input  wire logic                   BLOW_I,
	input  wire logic [VAC_W-1:0]       UPPER_SWITCH_POINT_I,
	input  wire logic [VAC_W-1:0]       UPPER_POINT_HYSTERESIS_I,
	input  wire logic [VAC_W-1:0]       PART_PRESENT_POINT_I,
	input  wire logic [VAC_W-1:0]       PART_PRESENT_HYSTERESIS_I,
	input  wire logic                   CONTROL_WITH_SHUTOFF_I,
	input  wire logic                   CONTINUOUS_SUCTION_INHIBIT_I,
	input  wire logic [13:0]            EVAC_LIMIT_I,
	input  wire logic                   EVAC_LIMIT_WR_I,
	input  wire logic                   AUTOSET_I,
	input  wire logic                   EXT_PRESSURE_VALID_I,
	input  wire logic [7:0]             EXT_PRESSURE_I,
	input  wire logic                   CLEAR_DIAG_I,
	input  wire logic                   FACTORY_RESET_I,
	input  wire logic                   ERR_EVENT_I,
	input  wire logic [CODE_W-1:0]      ERR_CODE_I,
	input  wire logic [5:0]             DIAG_IDX_I,
	input  wire logic [3:0]             TREND_IDX_I,
	output logic                        SUCTION_VALVE_O,
	output logic                        CONT_SUCTION_O,
	output logic                        UPPER_WARN_O,
	output logic                        EVAC_WARN_O,
	output logic                        LEAK_WARN_O,
	output logic                        DYN_WARN_O,
	output logic                        STATUS_YELLOW_O,
	output logic                        EVAC_REJECT_O,
	output logic [MS_W-1:0]             FIRST_EVACUATION_INTERVAL_O,
	output logic [MS_W-1:0]             SECOND_EVACUATION_INTERVAL_O,
	output logic [MS_W-1:0]             LEAK_RATE_O,
	output logic [VAC_W-1:0]            DYN_PRESSURE_O,
	output logic [6:0]                  PERF_O,
	output logic [6:0]                  AIR_PCT_O,
	output logic [31:0]                 AIR_ABS_O,
	output logic [MS_W-1:0]             LEAK_LIMIT_O,
	output logic [13:0]                 EVAC_LIMIT_O,
	output logic [CNT_W-1:0]            SUCTION_CYCLE_COUNTER_O,
	output logic [DIAG_W-1:0]           DIAG_ENTRY_O,
	output logic [5:0]                  DIAG_COUNT_O,
	output logic [TREND_W-1:0]          TREND_RECORD_O,
	output logic [3:0]                  TREND_COUNT_O
);
	// ************************************************
	// state
	// ************************************************
	typedef struct packed {
		vcm_phase_t                      phase;
		logic                            sig_d;
		logic [17:0]                     div;
		logic [MS_W-1:0]                 cyc_ms;
		logic [MS_W-1:0]                 act_ms;
		logic [MS_W-1:0]                 t1_cnt;
		logic                            h2_seen;
		logic                            h1_seen;
		logic                            dyn_done;
		logic [VAC_W-1:0]                leak_ref;
		logic [6:0]                      leak_ms;
		logic [1:0]                      strikes;
		logic                            valve;
		logic                            cont;
		logic                            w_upper;
		logic                            w_evac;
		logic                            w_leak;
		logic                            w_dyn;
		logic                            yellow;
		logic                            rej;
		logic [MS_W-1:0]                 t0;
		logic [MS_W-1:0]                 t1;
		logic [MS_W-1:0]                 leak_rate;
		logic [VAC_W-1:0]                dyn;
		logic [6:0]                      perf;
		logic [6:0]                      air_pct;
		logic [31:0]                     air_abs;
		logic [MS_W-1:0]                 leak_limit;
		logic [13:0]                     evac_limit;
		logic [CNT_W-1:0]                count;
		logic [DIAG_N-1:0][DIAG_W-1:0]   diag;
		logic [5:0]                      diag_n;
		logic [TREND_N-1:0][TREND_W-1:0] trend;
		logic [3:0]                      trend_n;
		logic [DIAG_W-1:0]               diag_rd;
		logic [TREND_W-1:0]              trend_rd;
	} vcm_state_t;

	vcm_state_t state_reg;
	vcm_state_t state_next;

	// ************************************************
	// next state
	// ************************************************
	always_comb
	begin
		logic             tick;
		logic             start;
		logic [VAC_W-1:0] pp_thr;
		logic [VAC_W-1:0] low_thr;
		logic [MS_W-1:0]  rate;
		logic [MS_W-1:0]  t1_lim;
		logic [22:0]      pct_wide;
		logic [16:0]      perf_wide;
		logic [CODE_W-1:0] code;
		logic             push;
		tick      = state_reg.div == 18'(TICK_CYCLES_P - 1);
		start     = SUCTION_I && !state_reg.sig_d;
		pp_thr    = (PART_PRESENT_POINT_I > PART_PRESENT_HYSTERESIS_I) ?
			PART_PRESENT_POINT_I - PART_PRESENT_HYSTERESIS_I : '0;
		low_thr   = (UPPER_SWITCH_POINT_I > UPPER_POINT_HYSTERESIS_I) ?
			UPPER_SWITCH_POINT_I - UPPER_POINT_HYSTERESIS_I : '0;
		rate      = '0;
		t1_lim    = '0;
		pct_wide  = '0;
		perf_wide = '0;
		code      = '0;
		push      = 1'b0;
		state_next       = state_reg;
		state_next.sig_d = SUCTION_I;
		state_next.rej   = 1'b0;
		state_next.div   = tick ? '0 : state_reg.div + 18'h00001;
		// cycle timing and air consumption
		if (tick && state_reg.cyc_ms != 16'hFFFF)
		begin
			state_next.cyc_ms = state_reg.cyc_ms + 16'h0001;
			if ((state_reg.valve || BLOW_I) && state_reg.act_ms != 16'hFFFF)
				state_next.act_ms = state_reg.act_ms + 16'h0001;
		end
		if (start)
		begin
			state_next.count = state_reg.count + 32'h00000001;
			if (state_reg.cyc_ms != '0)
			begin
				pct_wide = (23'(state_reg.act_ms) * 23'h000064) / 23'(state_reg.cyc_ms);
				state_next.air_pct = pct_wide[6:0];
			end
			state_next.air_abs = EXT_PRESSURE_VALID_I ?
				32'(state_reg.act_ms) * 32'(EXT_PRESSURE_I) * 32'(NOZZLE_K) : '0;
			state_next.cyc_ms   = '0;
			state_next.act_ms   = '0;
			state_next.t1_cnt   = '0;
			state_next.h2_seen  = 1'b0;
			state_next.h1_seen  = 1'b0;
			state_next.dyn_done = 1'b0;
			state_next.strikes  = '0;
			state_next.cont     = 1'b0;
			state_next.w_upper  = 1'b0;
			state_next.w_evac   = 1'b0;
			state_next.w_leak   = 1'b0;
			state_next.w_dyn    = 1'b0;
			state_next.phase    = VCM_EVAC;
			state_next.valve    = 1'b1;
		end
		else if (SUCTION_I)
		begin
			// evacuation intervals
			if (!state_reg.h2_seen && VACUUM_I >= PART_PRESENT_POINT_I)
			begin
				state_next.h2_seen = 1'b1;
				state_next.t0      = state_reg.cyc_ms;
			end
			if (state_reg.h2_seen && !state_reg.h1_seen)
			begin
				if (VACUUM_I >= UPPER_SWITCH_POINT_I)
				begin
					state_next.h1_seen = 1'b1;
					state_next.t1      = state_reg.t1_cnt;
				end
				else if (tick)
					state_next.t1_cnt = state_reg.t1_cnt + 16'h0001;
				if (state_reg.evac_limit != '0 &&
					state_reg.t1_cnt > 16'(state_reg.evac_limit))
					state_next.w_evac = 1'b1;
			end
			// dynamic pressure one second into the cycle
			if (!state_reg.dyn_done && state_reg.cyc_ms == 16'(DYN_TIME_MS))
			begin
				state_next.dyn_done = 1'b1;
				state_next.dyn = (VACUUM_I > UPPER_SWITCH_POINT_I) ? '0 : VACUUM_I;
				if (VACUUM_I > pp_thr && VACUUM_I < UPPER_SWITCH_POINT_I)
					state_next.w_dyn = 1'b1;
				if (VACUUM_I > UPPER_SWITCH_POINT_I || VACUUM_I == '0 || VACUUM_I > pp_thr)
					state_next.perf = '0;
				else
				begin
					perf_wide = (17'(VACUUM_I) * 17'h00064) / 17'(pp_thr);
					state_next.perf = PCT_FULL - perf_wide[6:0];
				end
			end
			// suction control and leakage
			case (state_reg.phase)
				VCM_EVAC:
				begin
					state_next.valve = 1'b1;
					if (CONTROL_WITH_SHUTOFF_I && VACUUM_I >= UPPER_SWITCH_POINT_I)
					begin
						state_next.phase    = VCM_HOLD;
						state_next.valve    = 1'b0;
						state_next.leak_ref = VACUUM_I;
						state_next.leak_ms  = '0;
					end
				end
				VCM_HOLD:
				begin
					if (!CONTROL_WITH_SHUTOFF_I || VACUUM_I <= low_thr)
					begin
						state_next.phase = VCM_EVAC;
						state_next.valve = 1'b1;
					end
					else if (tick)
					begin
						state_next.leak_ms = state_reg.leak_ms + 7'h01;
						if (state_reg.leak_ms == 7'(LEAK_WIN_MS - 1))
						begin
							rate = (VACUUM_I < state_reg.leak_ref) ?
								16'(state_reg.leak_ref - VACUUM_I) * 16'(LEAK_SCALE) : '0;
							state_next.leak_rate = rate;
							state_next.leak_ms   = '0;
							state_next.leak_ref  = VACUUM_I;
							if (rate > state_reg.leak_limit)
							begin
								state_next.w_leak  = 1'b1;
								state_next.valve   = 1'b1;
								state_next.strikes = state_reg.strikes + 2'h1;
								if (state_reg.strikes != '0 && !CONTINUOUS_SUCTION_INHIBIT_I)
								begin
									state_next.phase = VCM_CONT;
									state_next.cont  = 1'b1;
								end
								else
									state_next.phase = VCM_EVAC;
							end
						end
					end
				end
				VCM_CONT:
				begin
					state_next.valve = 1'b1;
					if (CONTINUOUS_SUCTION_INHIBIT_I)
					begin
						state_next.phase = VCM_EVAC;
						state_next.cont  = 1'b0;
					end
				end
				default:
					state_next.phase = VCM_EVAC;
			endcase
		end
		else
		begin
			state_next.phase = VCM_IDLE;
			state_next.valve = 1'b0;
			state_next.cont  = 1'b0;
			if (state_reg.sig_d && !state_reg.h1_seen)
				state_next.w_upper = 1'b1;
		end
		state_next.yellow = state_next.w_upper | state_next.w_evac |
			state_next.w_leak | state_next.w_dyn;
		// limit configuration and autoset
		if (EVAC_LIMIT_WR_I)
		begin
			if (EVAC_LIMIT_I > 14'(EVAC_MAX_MS))
				state_next.rej = 1'b1;
			else
				state_next.evac_limit = EVAC_LIMIT_I;
		end
		if (FACTORY_RESET_I)
		begin
			state_next.leak_limit = LEAK_LIMIT_RST;
			state_next.evac_limit = EVAC_LIMIT_RST;
		end
		if (AUTOSET_I)
		begin
			state_next.leak_limit = (state_reg.leak_rate > 16'hFFFF - LEAK_TOL) ?
				16'hFFFF : state_reg.leak_rate + LEAK_TOL;
			t1_lim = (state_reg.t1 > 16'(EVAC_MAX_MS) - EVAC_TOL) ?
				16'(EVAC_MAX_MS) : state_reg.t1 + EVAC_TOL;
			state_next.evac_limit = t1_lim[13:0];
			state_next.trend = {state_reg.trend[TREND_N-2:0],
				state_reg.t1, state_reg.leak_rate, state_reg.dyn, state_reg.count};
			if (state_reg.trend_n != 4'(TREND_N))
				state_next.trend_n = state_reg.trend_n + 4'h1;
		end
		// diagnostic events, clear first so a same-cycle event survives
		if (CLEAR_DIAG_I || FACTORY_RESET_I)
		begin
			state_next.diag   = '0;
			state_next.diag_n = '0;
		end
		push = 1'b1;
		if (state_next.w_upper && !state_reg.w_upper)
			code = EV_UPPER;
		else if (state_next.w_evac && !state_reg.w_evac)
			code = EV_EVAC;
		else if (state_next.w_leak && !state_reg.w_leak)
			code = EV_LEAK;
		else if (state_next.w_dyn && !state_reg.w_dyn)
			code = EV_DYN;
		else if (state_next.cont && !state_reg.cont)
			code = EV_CONT;
		else if (ERR_EVENT_I)
			code = ERR_CODE_I;
		else
			push = 1'b0;
		if (push)
		begin
			state_next.diag = {state_next.diag[DIAG_N-2:0], code, state_reg.count};
			if (state_next.diag_n != 6'(DIAG_N))
				state_next.diag_n = state_next.diag_n + 6'h01;
		end
		state_next.diag_rd  = (DIAG_IDX_I < 6'(DIAG_N)) ? state_reg.diag[DIAG_IDX_I] : '0;
		state_next.trend_rd = (TREND_IDX_I < 4'(TREND_N)) ? state_reg.trend[TREND_IDX_I] : '0;
	end

	// ************************************************
	// registers
	// ************************************************
	always_ff @(posedge SYS_CLK_I)
	begin
		if (!RST_N_I)
		begin
			state_reg            <= '0;
			state_reg.phase      <= VCM_IDLE;
			state_reg.leak_limit <= LEAK_LIMIT_RST;
			state_reg.evac_limit <= EVAC_LIMIT_RST;
		end
		else
			state_reg <= state_next;
	end

	assign SUCTION_VALVE_O              = state_reg.valve;
	assign CONT_SUCTION_O               = state_reg.cont;
	assign UPPER_WARN_O                 = state_reg.w_upper;
	assign EVAC_WARN_O                  = state_reg.w_evac;
	assign LEAK_WARN_O                  = state_reg.w_leak;
	assign DYN_WARN_O                   = state_reg.w_dyn;
	assign STATUS_YELLOW_O              = state_reg.yellow;
	assign EVAC_REJECT_O                = state_reg.rej;
	assign FIRST_EVACUATION_INTERVAL_O  = state_reg.t0;
	assign SECOND_EVACUATION_INTERVAL_O = state_reg.t1;
	assign LEAK_RATE_O                  = state_reg.leak_rate;
	assign DYN_PRESSURE_O               = state_reg.dyn;
	assign PERF_O                       = state_reg.perf;
	assign AIR_PCT_O                    = state_reg.air_pct;
	assign AIR_ABS_O                    = state_reg.air_abs;
	assign LEAK_LIMIT_O                 = state_reg.leak_limit;
	assign EVAC_LIMIT_O                 = state_reg.evac_limit;
	assign SUCTION_CYCLE_COUNTER_O      = state_reg.count;
	assign DIAG_ENTRY_O                 = state_reg.diag_rd;
	assign DIAG_COUNT_O                 = state_reg.diag_n;
	assign TREND_RECORD_O               = state_reg.trend_rd;
	assign TREND_COUNT_O                = state_reg.trend_n;

	// ************************************************
	// checks
	// ************************************************
	a_upper_missed: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		state_reg.sig_d && !SUCTION_I && !state_reg.h1_seen |=> UPPER_WARN_O && STATUS_YELLOW_O)
		else $error("upper point warning missing at suction end");
	a_upper_holds: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		UPPER_WARN_O && !SUCTION_I |=> UPPER_WARN_O)
		else $error("upper point warning dropped before next cycle");
	a_evac_enable: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		$rose(EVAC_WARN_O) |-> $past(EVAC_LIMIT_O) != '0)
		else $error("evacuation warning with monitoring off");
	a_evac_reject: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		EVAC_LIMIT_WR_I && EVAC_LIMIT_I > 14'(EVAC_MAX_MS) && !AUTOSET_I && !FACTORY_RESET_I
		|=> EVAC_REJECT_O && EVAC_LIMIT_O == $past(EVAC_LIMIT_O))
		else $error("oversized evacuation limit accepted");
	a_leak_mode: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		state_reg.phase == VCM_HOLD && $past(state_reg.phase) != VCM_HOLD
		|-> $past(CONTROL_WITH_SHUTOFF_I) && !SUCTION_VALVE_O)
		else $error("leakage hold entered outside shutoff mode");
	a_leak_yellow: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		LEAK_WARN_O |-> STATUS_YELLOW_O)
		else $error("leakage warning without yellow light");
	a_cont_inhibit: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		CONTINUOUS_SUCTION_INHIBIT_I ##1 CONTINUOUS_SUCTION_INHIBIT_I |-> !CONT_SUCTION_O)
		else $error("continuous suction despite inhibit");
	a_perf_zero: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		$rose(state_reg.dyn_done) && DYN_PRESSURE_O == '0 |-> PERF_O == '0)
		else $error("performance not zero for invalid pressure");
	a_trend_push: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		AUTOSET_I && TREND_COUNT_O != 4'(TREND_N) |=> TREND_COUNT_O == $past(TREND_COUNT_O) + 4'h1)
		else $error("autoset saved no trend record");
	a_cycle_count: assert property (@(posedge SYS_CLK_I) disable iff (!RST_N_I)
		SUCTION_I && !state_reg.sig_d
		|=> SUCTION_CYCLE_COUNTER_O == $past(SUCTION_CYCLE_COUNTER_O) + 32'h00000001)
		else $error("suction cycle not counted");
endmodule

// [verilog/vcm_pkg.sv]
// Purpose: constants and types of the vacuum condition monitor
// Assumes: 250 MHz system clock, vacuum and thresholds in mbar
// Notes:   one millisecond tick drives every interval measurement
//
// Summary of operation
// - upper point never reached in a cycle raises warning, light yellow.
// - upper point warning appears at suction end, holds until next cycle.
// - second evacuation interval above limit raises warning, light yellow.
// - evacuation limit of zero switches evacuation monitoring off.
// - evacuation limit above 9.99 s is refused.
// - leakage rate in mbar/s is monitored only in shutoff control mode.
// - low leakage lets vacuum fall to upper point minus hysteresis, no warning.
// - high leakage resumes suction at once, raises warning, light yellow.
// - second leakage limit violation switches to continuous suction.
// - continuous suction inhibit keeps the block out of continuous suction.
// - dynamic pressure between part-present threshold and upper point warns.
// - first interval in ms runs from suction on to part-present point.
// - second interval in ms runs from part-present point to upper point.
// - autoset stores last leakage and interval plus margin as new limits.
// - air consumption percent is suction plus blow-off time over cycle time.
// - absolute air consumption only with an externally supplied pressure.
// - leakage measurement starts only after shutoff at the upper point.
// - dynamic pressure sampled one second after start, above upper reads 0.
// - performance is 0% above part-present threshold or at 0 mbar.
// - diagnostic buffer keeps 38 newest events, each with cycle count.
// - event logging runs in every mode, cleared by command or factory reset.
// - each autoset saves a trend record into a ten-entry buffer.
// - suction cycle counter counts every suction pulse, cleared only by RST_N_I.
package vcm_pkg;
	// ************************************************
	// timing
	// ************************************************
	localparam int CLK_PERIOD_PS  = 4000;
	localparam int TICK_PERIOD_NS = 1000000;
	localparam int TICK_CYCLES    = TICK_PERIOD_NS * 1000 / CLK_PERIOD_PS;
	localparam int DYN_TIME_MS    = 1000;
	localparam int LEAK_WIN_MS    = 100;
	localparam int LEAK_SCALE     = 1000 / LEAK_WIN_MS;
	localparam int EVAC_MAX_MS    = 9990;
	// ************************************************
	// widths and sizes
	// ************************************************
	localparam int VAC_W   = 10;
	localparam int MS_W    = 16;
	localparam int CNT_W   = 32;
	localparam int CODE_W  = 4;
	localparam int DIAG_N  = 38;
	localparam int TREND_N = 10;
	localparam int DIAG_W  = CODE_W + CNT_W;
	localparam int TREND_W = MS_W + MS_W + VAC_W + CNT_W;
	// ************************************************
	// diagnostic event codes
	// ************************************************
	localparam logic [CODE_W-1:0] EV_UPPER = 4'h1;
	localparam logic [CODE_W-1:0] EV_EVAC  = 4'h2;
	localparam logic [CODE_W-1:0] EV_LEAK  = 4'h3;
	localparam logic [CODE_W-1:0] EV_DYN   = 4'h4;
	localparam logic [CODE_W-1:0] EV_CONT  = 4'h5;
	// ************************************************
	// reset values
	// ************************************************
	localparam logic [MS_W-1:0] LEAK_LIMIT_RST = 16'h0064;
	localparam logic [13:0]     EVAC_LIMIT_RST = 14'h0000;
	localparam logic [6:0]      PCT_FULL       = 7'h64;
	typedef enum logic [2:0] {VCM_IDLE, VCM_EVAC, VCM_HOLD, VCM_CONT} vcm_phase_t;
endpackage
